//--- rtl/fault_resp_defs.svh
`ifndef FAULT_RESP_DEFS_SVH
`define FAULT_RESP_DEFS_SVH

// hardware configuration register one: read fault exception enable position
`define CFG_ONE_RFX_BIT     46
`define CFG_ONE_WIDTH       64
`define CFG_ONE_RESET       64'h0000000000000000
// revision codes for the core variant parameter
`define CORE_REV_EARLY      1'b0
`define CORE_REV_LATE       1'b1
// depth of the pending-tag table
`define TAG_DEPTH           8
`define TAG_AW              3

`endif

//--- rtl/fault_resp_pkg.sv
package fault_resp_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STALL,
    ST_MCHK,
    ST_CHECKSTOP
  } resp_state_t;

endpackage : fault_resp_pkg

//--- rtl/fault_tag_mem.sv
`timescale 1ns/100ps
`include "fault_resp_defs.svh"

// remembers the fault mark of each outstanding fetch or load tag
module fault_tag_mem #(
  parameter int DEPTH = `TAG_DEPTH,
  parameter int AW    = `TAG_AW
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          reset_n,
  // write side: returned data with its fault mark
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_tag,
  input  wire logic          wr_fault,
  // read side: mark of the tag about to be used
  input  wire logic [AW-1:0] rd_tag,
  output logic               rd_fault
);

  logic [DEPTH-1:0] mark_reg;
  logic [DEPTH-1:0] mark_next;
  logic             rd_next;

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("fault_tag_mem: DEPTH must equal 2**AW");
  end

  always_comb begin
    mark_next = mark_reg;
    if (wr_en) begin
      mark_next[wr_tag] = wr_fault;
    end
    // bypass so a mark written this cycle reaches rd_fault at the next edge, together with the write
    rd_next = (wr_en && wr_tag == rd_tag) ? wr_fault : mark_reg[rd_tag];
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mark_reg <= '0;
      rd_fault <= 1'b0;
    end else begin
      mark_reg <= mark_next;
      rd_fault <= rd_next;
    end
  end

endmodule : fault_tag_mem

//--- rtl/read_fault_machine_check.sv
// What this block does
// - enable bit 46 gates machine check generation
// - enable clear: fault never raises machine check
// - enable clear, later revision: faulty fetches and loads never execute
// - later revision: stall on non-speculative faulty use until asynchronous interrupt
// - earlier revision: keep running with faulty values
// - enable set: machine check before faulty use
// - enable set: check if enabled, else checkstop
`timescale 1ns/100ps
`include "fault_resp_defs.svh"

module read_fault_machine_check #(
  parameter logic CORE_REV = `CORE_REV_LATE,
  parameter int   DEPTH    = `TAG_DEPTH,
  parameter int   AW       = `TAG_AW
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  // configuration register write port
  input  wire logic                      cfg_wr,
  input  wire logic [`CFG_ONE_WIDTH-1:0] cfg_wdata,
  output logic      [`CFG_ONE_WIDTH-1:0] hardware_config_reg_one,
  // machine state enable
  input  wire logic                      machine_check_enable,
  // returned data from cache or bus
  input  wire logic                      ret_valid,
  input  wire logic [AW-1:0]             ret_tag,
  input  wire logic                      core_fault_in,
  // execution side: instruction or load about to use a tag
  input  wire logic                      use_req,
  input  wire logic [AW-1:0]             use_tag,
  input  wire logic                      use_nonspec,
  output logic                           use_ok,
  output logic                           use_suppress,
  // asynchronous interrupt taken by the core
  input  wire logic                      async_irq_taken,
  // outcomes
  output logic                           core_stall,
  output logic                           mchk_irq,
  output logic                           checkstop
);

  ////////////////////////////////////////////////////////////////////////////

  if (`CFG_ONE_RFX_BIT >= `CFG_ONE_WIDTH) begin : g_bad_bit
    $error("read_fault_machine_check: enable bit outside register");
  end

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("read_fault_machine_check: DEPTH must equal 2**AW");
  end

  function automatic logic rfx_of(input logic [`CFG_ONE_WIDTH-1:0] r);
    rfx_of = r[`CFG_ONE_RFX_BIT];
  endfunction : rfx_of

  // where an enabled fault sends the core
  function automatic fault_resp_pkg::resp_state_t fault_target(
    input logic me
  );
    fault_target = me ? fault_resp_pkg::ST_MCHK
                      : fault_resp_pkg::ST_CHECKSTOP;
  endfunction : fault_target

  ////////////////////////////////////////////////////////////////////////////
  // configuration register

  logic [`CFG_ONE_WIDTH-1:0] cfg_reg;
  logic [`CFG_ONE_WIDTH-1:0] cfg_next;
  logic                      read_fault_exception_enable;

  always_comb begin
    cfg_next = cfg_wr ? cfg_wdata : cfg_reg;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= `CFG_ONE_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign hardware_config_reg_one     = cfg_reg;
  assign read_fault_exception_enable = rfx_of(cfg_reg);

  ////////////////////////////////////////////////////////////////////////////
  // fault marks per outstanding tag, filled by outside logic

  logic use_fault;

  fault_tag_mem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_marks (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .wr_en    (ret_valid),
    .wr_tag   (ret_tag),
    .wr_fault (core_fault_in),
    .rd_tag   (use_tag),
    .rd_fault (use_fault)
  );

  // the mark lands one cycle after the tag; align the request with it
  logic          use_req_reg;
  logic          use_req_next;
  logic          nonspec_reg;
  logic          nonspec_next;

  always_comb begin
    use_req_next = use_req;
    nonspec_next = use_nonspec;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      use_req_reg <= 1'b0;
      nonspec_reg <= 1'b0;
    end else begin
      use_req_reg <= use_req_next;
      nonspec_reg <= nonspec_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response state machine

  fault_resp_pkg::resp_state_t state_reg;
  fault_resp_pkg::resp_state_t state_next;
  logic                        bad_use;
  logic                        fault_evt;

  assign bad_use   = use_req_reg && use_fault;
  assign fault_evt = ret_valid && core_fault_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fault_resp_pkg::ST_RUN: begin
        if (read_fault_exception_enable && fault_evt) begin
          state_next = fault_target(machine_check_enable);
        end else if (!read_fault_exception_enable && bad_use &&
                     nonspec_reg && CORE_REV == `CORE_REV_LATE) begin
          state_next = fault_resp_pkg::ST_STALL;
        end
      end
      fault_resp_pkg::ST_STALL: begin
        if (async_irq_taken) begin
          state_next = fault_resp_pkg::ST_RUN;
        end
      end
      fault_resp_pkg::ST_MCHK: begin
        // a fault arriving while the pulse stands is not lost
        if (read_fault_exception_enable && fault_evt) begin
          state_next = fault_target(machine_check_enable);
        end else begin
          state_next = fault_resp_pkg::ST_RUN;
        end
      end
      fault_resp_pkg::ST_CHECKSTOP: begin
        state_next = fault_resp_pkg::ST_CHECKSTOP;
      end
      default: begin
        state_next = fault_resp_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= fault_resp_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outcome flags, registered from the next state so they track state_reg

  logic stall_reg;
  logic stall_next;
  logic mchk_reg;
  logic mchk_next;
  logic cstop_reg;
  logic cstop_next;

  always_comb begin
    stall_next = (state_next == fault_resp_pkg::ST_STALL) ||
                 (state_next == fault_resp_pkg::ST_CHECKSTOP);
    // only reachable with the enable set
    mchk_next  = (state_next == fault_resp_pkg::ST_MCHK);
    cstop_next = (state_next == fault_resp_pkg::ST_CHECKSTOP);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stall_reg <= 1'b0;
      mchk_reg  <= 1'b0;
      cstop_reg <= 1'b0;
    end else begin
      stall_reg <= stall_next;
      mchk_reg  <= mchk_next;
      cstop_reg <= cstop_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic suppress;

  always_comb begin
    // earlier revision lets faulty values through when disabled
    suppress = bad_use &&
               (read_fault_exception_enable ||
                CORE_REV == `CORE_REV_LATE);
  end

  assign use_suppress = use_req_reg && (suppress ||
                        state_reg != fault_resp_pkg::ST_RUN);
  assign use_ok       = use_req_reg && !use_suppress;
  assign core_stall   = stall_reg;
  assign mchk_irq     = mchk_reg;
  assign checkstop    = cstop_reg;

endmodule : read_fault_machine_check

//--- bench/rfmc_monitor.sv
`timescale 1ns/100ps
`include "fault_resp_defs.svh"
module rfmc_monitor #(parameter logic CORE_REV = 1'b1, parameter int AW = 3) (
  // clock, reset and inputs
  input wire logic mclk, reset_n, cfg_wr, machine_check_enable,
  input wire logic [`CFG_ONE_WIDTH-1:0] cfg_wdata, hardware_config_reg_one,
  input wire logic ret_valid, core_fault_in, use_req, use_nonspec,
  input wire logic [AW-1:0] ret_tag, use_tag,
  // outcomes, and the asynchronous interrupt taken by the core
  input wire logic use_ok, use_suppress, async_irq_taken,
  input wire logic core_stall, mchk_irq, checkstop
);
  logic [(1<<AW)-1:0] mark_reg, mark_next;
  logic en, run, bad;
  always_comb begin
    mark_next = mark_reg;
    if (ret_valid) mark_next[ret_tag] = core_fault_in;
  end
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) mark_reg <= '0; else mark_reg <= mark_next;
  assign en = hardware_config_reg_one[`CFG_ONE_RFX_BIT];
  assign run = !core_stall && !mchk_irq;
  assign bad = use_req && !ret_valid && mark_reg[use_tag];
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence flt_s; ret_valid && core_fault_in && !core_stall; endsequence
  sequence ok_s; use_ok ##1 !core_stall; endsequence
  a_cfg_load: assert property (cfg_wr |=>
    hardware_config_reg_one == $past(cfg_wdata)) else $error("cfg load");
  a_off_quiet: assert property (flt_s and !en |=> !mchk_irq)
    else $error("mchk while off");
  a_mchk_on: assert property (
    flt_s and en && machine_check_enable |=> mchk_irq) else $error("no mchk");
  a_cstop_on: assert property (
    flt_s and en && !machine_check_enable |=> checkstop) else $error("no cs");
  a_cstop_keep: assert property (checkstop |=> checkstop)
    else $error("checkstop lost");
  a_use_answer: assert property (use_req |=> use_ok != use_suppress)
    else $error("use answer");
  a_bad_blocked: assert property (
    bad |=> use_suppress || !(en || CORE_REV)) else $error("faulty used");
  a_early_runs: assert property (
    bad && !en && !CORE_REV && run |=> ok_s) else $error("early stalled");
  a_late_stall: assert property (
    bad && !en && CORE_REV && use_nonspec && run |=> ##1 core_stall)
    else $error("no stall");
  a_stall_hold: assert property (
    core_stall && !async_irq_taken |=> core_stall) else $error("stall lost");
endmodule : rfmc_monitor
bind read_fault_machine_check rfmc_monitor #(.CORE_REV(CORE_REV), .AW(AW))
  rfmc_monitor_i (.mclk(mclk), .reset_n(reset_n), .cfg_wr(cfg_wr),
  .machine_check_enable(machine_check_enable), .cfg_wdata(cfg_wdata),
  .hardware_config_reg_one(hardware_config_reg_one), .ret_valid(ret_valid),
  .core_fault_in(core_fault_in), .use_req(use_req), .ret_tag(ret_tag),
  .use_nonspec(use_nonspec), .use_tag(use_tag), .use_ok(use_ok),
  .use_suppress(use_suppress), .async_irq_taken(async_irq_taken),
  .core_stall(core_stall), .mchk_irq(mchk_irq), .checkstop(checkstop));

//--- bench/fetch_return_model.sv
`timescale 1ns/100ps
module fetch_return_model (
  // fetch order from the bench
  input wire logic       mclk, fetch_go, fetch_bad,
  input wire logic [2:0] fetch_tag, fetch_lag,
  // return toward the core
  output logic       ret_valid, core_fault_in,
  output logic [2:0] ret_tag
);
  initial begin
    ret_valid = 1'b0;
    ret_tag = 3'h0;
    core_fault_in = 1'b0;
  end
  always @(posedge mclk) if (fetch_go) begin
    repeat (fetch_lag) @(posedge mclk);
    ret_valid <= 1'b1;
    ret_tag <= fetch_tag;
    core_fault_in <= fetch_bad;
    @(posedge mclk);
    ret_valid <= 1'b0;
    ret_tag <= ~fetch_tag;
    core_fault_in <= ~fetch_bad;
  end
endmodule : fetch_return_model

//--- bench/read_fault_machine_check_tb.sv
`timescale 1ns/100ps
module read_fault_machine_check_tb;
  logic mclk = 0, reset_n = 0, cfg_wr = 0, machine_check_enable = 0;
  logic use_req = 0, use_nonspec = 0, async_irq_taken = 0;
  logic fetch_go = 0, fetch_bad = 0, ret_valid, core_fault_in;
  logic [2:0] use_tag = 3'h0, fetch_tag = 3'h0, fetch_lag = 3'h0, ret_tag;
  logic [63:0] cfg_wdata = 64'h0, cfg_q [2];
  logic ok [2], sup [2], stall [2], mc [2], cs [2];
  int miscompares = 0, cmp_count = 0;
  initial forever #2.5 mclk = ~mclk;
  fetch_return_model fetch_return_model_i (.mclk(mclk), .fetch_go(fetch_go),
    .fetch_bad(fetch_bad), .fetch_tag(fetch_tag), .fetch_lag(fetch_lag),
    .ret_valid(ret_valid), .core_fault_in(core_fault_in), .ret_tag(ret_tag));
  for (genvar g = 0; g < 2; g++) begin : rev
    read_fault_machine_check #(.CORE_REV(g == 1)) read_fault_machine_check_i (
      .mclk(mclk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .hardware_config_reg_one(cfg_q[g]), .use_req(use_req),
      .machine_check_enable(machine_check_enable), .ret_valid(ret_valid),
      .ret_tag(ret_tag), .core_fault_in(core_fault_in), .use_tag(use_tag),
      .use_nonspec(use_nonspec), .use_ok(ok[g]), .use_suppress(sup[g]),
      .async_irq_taken(async_irq_taken), .core_stall(stall[g]),
      .mchk_irq(mc[g]), .checkstop(cs[g]));
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic step(int n = 1);
    repeat (n) @(posedge mclk);
  endtask : step
  task automatic wr(logic [63:0] d, logic me);
    step;
    cfg_wdata <= d;
    cfg_wr <= 1;
    machine_check_enable <= me;
    step;
    cfg_wr <= 0;
    #1 chk("cfg", d, cfg_q[1]);
  endtask : wr
  task automatic fetch(logic [2:0] t, logic bad, logic [2:0] lag);
    int i;
    step;
    fetch_tag <= t;
    fetch_bad <= bad;
    fetch_lag <= lag;
    fetch_go <= 1;
    step;
    fetch_go <= 0;
    i = 0;
    do begin step; i++; end while (!ret_valid && i < 20);
    chk("ret valid", 1, ret_valid);
    #1;
  endtask : fetch
  task automatic use_tag_now(logic [2:0] t, logic ns = 1);
    step;
    use_req <= 1;
    use_tag <= t;
    use_nonspec <= ns;
    step;
    use_req <= 0;
    #1;
  endtask : use_tag_now
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_off;
    wr(64'h0, 1);
    fetch(3'h1, 1, 3);
    chk("mc off", 0, {mc[1], mc[0]});
    use_tag_now(3'h1);
    chk("late sup", 1, sup[1]);
    chk("early ok", 1, ok[0]);
    step(4);
    #1 chk("stall", 2'h2, {stall[1], stall[0]});
    step;
    async_irq_taken <= 1;
    step;
    async_irq_taken <= 0;
    step(2);
    #1 chk("unstall", 0, stall[1]);
    use_tag_now(3'h1, 0);
    chk("spec sup", 2'h2, {sup[1], sup[0]});
    step(2);
    #1 chk("spec run", 0, {stall[1], stall[0]});
    fetch(3'h2, 0, 0);
    use_tag_now(3'h2);
    chk("clean ok", 2'h3, {ok[1], ok[0]});
    $display("test off done");
  endtask : t_off
  task automatic t_on;
    wr(64'h0000400000000000, 1);
    chk("cfg early", 64'h0000400000000000, cfg_q[0]);
    fetch(3'h4, 1, 0);
    chk("mc on", 2'h3, {mc[1], mc[0]});
    step;
    #1 chk("mc pulse", 0, {mc[1], mc[0]});
    use_tag_now(3'h4);
    chk("sup on", 2'h3, {sup[1], sup[0]});
    wr(64'h0000400000000000, 0);
    fetch(3'h5, 1, 2);
    chk("cs", 2'h3, {cs[1], cs[0]});
    step(3);
    #1 chk("cs held", 2'h3, {cs[1], cs[0]});
    chk("cs stall", 2'h3, {stall[1], stall[0]});
    $display("test on done");
  endtask : t_on
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    step(10);
    reset_n <= 1;
    t_off;
    t_on;
    summarize;
  end
  initial begin
    #20000;
    miscompares++;
    summarize;
  end
endmodule : read_fault_machine_check_tb
